// File: hw/mmdec_pkg.sv
// package: address map constants and select bundle for the memory map decoder
package mmdec_pkg;
  localparam int ADDR_W = 16;

  // region bounds
  localparam logic [15:0] IO_LO = 16'h0000;
  localparam logic [15:0] IO_HI = 16'h003F;
  localparam logic [15:0] RAM_LO = 16'h0040;
  localparam logic [15:0] RAM_HI = 16'h023F;
  localparam logic [15:0] ROM_LO = 16'hC000;
  localparam logic [15:0] ROM_HI = 16'hFDFF;
  localparam logic [15:0] MON_LO = 16'hFE20;
  localparam logic [15:0] MON_HI = 16'hFF52;
  localparam logic [15:0] VEC_LO = 16'hFFDC;
  localparam logic [15:0] VEC_HI = 16'hFFFF;

  // reserved locations (decode legal, no select)
  localparam logic [15:0] RSV_SUB = 16'hFE02;
  localparam logic [15:0] RSV_A = 16'hFE07;
  localparam logic [15:0] RSV_B = 16'hFE08;
  localparam logic [15:0] RSV_MON_LO = 16'hFE10;
  localparam logic [15:0] RSV_MON_HI = 16'hFE1F;
  localparam logic [15:0] RSV_C = 16'hFF7E;

  // high page system registers
  localparam logic [15:0] BRK_STAT = 16'hFE00;
  localparam logic [15:0] RST_SRC = 16'hFE01;
  localparam logic [15:0] BRK_FLAG = 16'hFE03;
  localparam logic [15:0] IRQ_ONE = 16'hFE04;
  localparam logic [15:0] IRQ_TWO = 16'hFE05;
  localparam logic [15:0] IRQ_THREE = 16'hFE06;
  localparam logic [15:0] BKP_HIGH = 16'hFE09;
  localparam logic [15:0] BKP_LOW = 16'hFE0A;
  localparam logic [15:0] BKP_CTRL = 16'hFE0B;
  localparam logic [15:0] LOW_VOLT = 16'hFE0C;
  localparam logic [15:0] WDOG_CTRL = 16'hFFFF;

  // region selects
  typedef struct packed {
    logic io_sel;
    logic ram_sel;
    logic rom_sel;
    logic mon_sel;
    logic vec_sel;
  } mmdec_region_t;

  // system register selects
  typedef struct packed {
    logic break_status_sel;
    logic reset_source_status_sel;
    logic break_flag_control_sel;
    logic irq_status_one_sel;
    logic irq_status_two_sel;
    logic irq_status_three_sel;
    logic breakpoint_addr_high_sel;
    logic breakpoint_addr_low_sel;
    logic breakpoint_ctrl_sel;
    logic low_voltage_status_sel;
    logic watchdog_ctrl_sel;
  } mmdec_sysreg_t;

  // registered state of the top
  typedef struct packed {
    mmdec_region_t region;
    mmdec_sysreg_t sysreg;
    logic reserved;
    logic illegal;
  } mmdec_state_t;
endpackage

// File: hw/mmdec_sysreg.sv
// high page system register select decoder (combinational)
`timescale 1ns/1ps
module mmdec_sysreg (
  // address
  input wire logic [15:0] i_addr,
  // selects
  output mmdec_pkg::mmdec_sysreg_t o_sel
);
  // one equality compare per register; reserved gaps fall through unselected
  always_comb begin
    o_sel = '0;
    o_sel.break_status_sel = (i_addr == mmdec_pkg::BRK_STAT);
    o_sel.reset_source_status_sel = (i_addr == mmdec_pkg::RST_SRC);
    o_sel.break_flag_control_sel = (i_addr == mmdec_pkg::BRK_FLAG);
    o_sel.irq_status_one_sel = (i_addr == mmdec_pkg::IRQ_ONE);
    o_sel.irq_status_two_sel = (i_addr == mmdec_pkg::IRQ_TWO);
    o_sel.irq_status_three_sel = (i_addr == mmdec_pkg::IRQ_THREE);
    o_sel.breakpoint_addr_high_sel = (i_addr == mmdec_pkg::BKP_HIGH);
    o_sel.breakpoint_addr_low_sel = (i_addr == mmdec_pkg::BKP_LOW);
    o_sel.breakpoint_ctrl_sel = (i_addr == mmdec_pkg::BKP_CTRL);
    o_sel.low_voltage_status_sel = (i_addr == mmdec_pkg::LOW_VOLT);
    o_sel.watchdog_ctrl_sel = (i_addr == mmdec_pkg::WDOG_CTRL);
  end
endmodule

// File: hw/mmdec_top.sv
// memory map address decoder: region selects, system register selects, illegal flag
// What this block does
// - takes a 16-bit address and puts every address into exactly one class, except $FFFF (vector table and watchdog control)
// - $0000-$003F selects the I/O register page
// - $0040-$023F selects the 512-byte RAM
// - $C000-$FDFF selects the user ROM
// - $FFDC-$FFFF selects the vector table
// - $FE20-$FF52 selects the monitor ROM
// - unimplemented accesses raise an illegal-address indication
// - $FE00, $FE01, $FE03 select break, reset-source, break-flag registers
// - $FE04-$FE06 select the three interrupt status registers
// - $FE09-$FE0B select breakpoint high, low and control registers
// - $FE0C selects low-voltage status; $FFFF also selects watchdog control
// - the illegal-address pulse feeds the system reset logic
`timescale 1ns/1ps
module mmdec_top (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // bus from the core
  input wire logic [15:0] i_addr,
  input wire logic i_access,
  // selects
  output mmdec_pkg::mmdec_region_t o_region,
  output mmdec_pkg::mmdec_sysreg_t o_sysreg,
  output logic o_reserved,
  // to reset logic
  output logic o_illegal_rst
);
  mmdec_pkg::mmdec_state_t state_ff;
  mmdec_pkg::mmdec_state_t nxt_state;
  mmdec_pkg::mmdec_sysreg_t sys_sel;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // -----------------------------------------------------------------
  // high page register decode
  // -----------------------------------------------------------------
  mmdec_sysreg u_sysreg (
    .i_addr(i_addr),
    .o_sel(sys_sel)
  );

  // -----------------------------------------------------------------
  // decode; outputs registered so data outputs come from flops
  // -----------------------------------------------------------------
  // selects only assert during a bus access, keeping idle cycles quiet
  always_comb begin
    logic rsv;
    logic any;
    rsv = 1'b0;
    any = 1'b0;
    nxt_state = '0;
    nxt_state.region.io_sel = i_access && in_rng(i_addr, mmdec_pkg::IO_LO, mmdec_pkg::IO_HI);
    nxt_state.region.ram_sel = i_access && in_rng(i_addr, mmdec_pkg::RAM_LO, mmdec_pkg::RAM_HI);
    nxt_state.region.rom_sel = i_access && in_rng(i_addr, mmdec_pkg::ROM_LO, mmdec_pkg::ROM_HI);
    nxt_state.region.mon_sel = i_access && in_rng(i_addr, mmdec_pkg::MON_LO, mmdec_pkg::MON_HI);
    nxt_state.region.vec_sel = i_access && in_rng(i_addr, mmdec_pkg::VEC_LO, mmdec_pkg::VEC_HI);
    nxt_state.sysreg = i_access ? sys_sel : '0;
    // reserved locations decode legal but select nothing
    rsv = (i_addr == mmdec_pkg::RSV_SUB) || (i_addr == mmdec_pkg::RSV_A) || (i_addr == mmdec_pkg::RSV_B)
      || in_rng(i_addr, mmdec_pkg::RSV_MON_LO, mmdec_pkg::RSV_MON_HI) || (i_addr == mmdec_pkg::RSV_C);
    nxt_state.reserved = i_access && rsv;
    any = (|nxt_state.region) || (|nxt_state.sysreg) || nxt_state.reserved;
    // anything else is a hole in the map and must reset the part
    nxt_state.illegal = i_access && !any;
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= '0;
    end else if (i_clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign o_region = state_ff.region;
  assign o_sysreg = state_ff.sysreg;
  assign o_reserved = state_ff.reserved;
  assign o_illegal_rst = state_ff.illegal;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  property p_io_sel;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_access && i_addr <= mmdec_pkg::IO_HI) |=> o_region.io_sel;
  endproperty
  a_io_sel: assert property (p_io_sel) else $error("io page not selected");

  property p_ram_sel;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_access) |=>
        (o_region.ram_sel == ($past(i_addr) >= mmdec_pkg::RAM_LO && $past(i_addr) <= mmdec_pkg::RAM_HI));
  endproperty
  a_ram_sel: assert property (p_ram_sel) else $error("ram select wrong");

  property p_rom_sel;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_access) |=>
        (o_region.rom_sel == ($past(i_addr) >= mmdec_pkg::ROM_LO && $past(i_addr) <= mmdec_pkg::ROM_HI));
  endproperty
  a_rom_sel: assert property (p_rom_sel) else $error("rom select wrong");

  property p_vec_sel;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_access) |=>
        (o_region.vec_sel == ($past(i_addr) >= mmdec_pkg::VEC_LO && $past(i_addr) <= mmdec_pkg::VEC_HI));
  endproperty
  a_vec_sel: assert property (p_vec_sel) else $error("vector select wrong");

  property p_mon_sel;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_access) |=>
        (o_region.mon_sel == ($past(i_addr) >= mmdec_pkg::MON_LO && $past(i_addr) <= mmdec_pkg::MON_HI));
  endproperty
  a_mon_sel: assert property (p_mon_sel) else $error("monitor select wrong");

  property p_hole;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_access && i_addr > mmdec_pkg::RAM_HI && i_addr < mmdec_pkg::ROM_LO) |=> o_illegal_rst;
  endproperty
  a_hole: assert property (p_hole) else $error("hole not flagged illegal");

  property p_illegal_only;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      o_illegal_rst |-> (o_region == '0 && o_sysreg == '0 && !o_reserved);
  endproperty
  a_illegal_only: assert property (p_illegal_only) else $error("illegal with a select");

  property p_onehot;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      $onehot0({o_region, o_sysreg.break_status_sel, o_sysreg.reset_source_status_sel,
        o_sysreg.break_flag_control_sel, o_sysreg.irq_status_one_sel, o_sysreg.irq_status_two_sel,
        o_sysreg.irq_status_three_sel, o_sysreg.breakpoint_addr_high_sel, o_sysreg.breakpoint_addr_low_sel,
        o_sysreg.breakpoint_ctrl_sel, o_sysreg.low_voltage_status_sel, o_reserved, o_illegal_rst});
  endproperty
  a_onehot: assert property (p_onehot) else $error("selects not exclusive");

  property p_class;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_access) |=> ((|o_region) || (|o_sysreg) || o_reserved || o_illegal_rst);
  endproperty
  a_class: assert property (p_class) else $error("address not classified");

  property p_wdog;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      o_sysreg.watchdog_ctrl_sel |-> o_region.vec_sel;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog without vector");

  property p_breaks;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_access && i_addr == mmdec_pkg::BKP_CTRL) |=> (o_sysreg.breakpoint_ctrl_sel && !o_illegal_rst);
  endproperty
  a_breaks: assert property (p_breaks) else $error("breakpoint control not selected");

  property p_irq;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_access && i_addr == mmdec_pkg::IRQ_TWO) |=> o_sysreg.irq_status_two_sel;
  endproperty
  a_irq: assert property (p_irq) else $error("irq status two not selected");

  property p_brk;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_access && i_addr == mmdec_pkg::RSV_SUB) |=> (o_reserved && !o_sysreg.break_status_sel);
  endproperty
  a_brk: assert property (p_brk) else $error("fe02 not reserved");

  // no access with the clock enable high means every select and the reset request stay quiet
  property p_idle;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && !i_access) |=> (o_region == '0 && o_sysreg == '0 && !o_reserved && !o_illegal_rst);
  endproperty
  a_idle: assert property (p_idle) else $error("select without access");

  // clock enable low holds every output where it was
  property p_freeze;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      !i_clk_en |=> ($stable(o_region) && $stable(o_sysreg) && $stable(o_reserved) && $stable(o_illegal_rst));
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");

  property p_rsv;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_access && (i_addr == mmdec_pkg::RSV_A || i_addr == mmdec_pkg::RSV_B
        || i_addr == mmdec_pkg::RSV_C)) |=> (o_reserved && !o_illegal_rst);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved byte not marked");

  // the small hole between low-voltage status and the monitor gap is illegal
  property p_gap;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_access && i_addr > mmdec_pkg::LOW_VOLT && i_addr < mmdec_pkg::RSV_MON_LO) |=> o_illegal_rst;
  endproperty
  a_gap: assert property (p_gap) else $error("high page hole not illegal");

  property p_low_volt;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_access && i_addr == mmdec_pkg::LOW_VOLT) |=> o_sysreg.low_voltage_status_sel;
  endproperty
  a_low_volt: assert property (p_low_volt) else $error("low voltage status not selected");

  property p_wdog_vec;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_access && i_addr == mmdec_pkg::WDOG_CTRL) |=> (o_sysreg.watchdog_ctrl_sel && o_region.vec_sel);
  endproperty
  a_wdog_vec: assert property (p_wdog_vec) else $error("top byte not double selected");

  property p_rst_src;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_access && i_addr == mmdec_pkg::RST_SRC) |=> (o_sysreg.reset_source_status_sel && !o_illegal_rst);
  endproperty
  a_rst_src: assert property (p_rst_src) else $error("reset source not selected");

  property p_bkp_high;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_access && i_addr == mmdec_pkg::BKP_HIGH) |=> o_sysreg.breakpoint_addr_high_sel;
  endproperty
  a_bkp_high: assert property (p_bkp_high) else $error("breakpoint high not selected");
endmodule

// File: verification/mmdec_core_model.sv
// processor core model that puts addresses and access strobes on the decoder bus
`timescale 1ns/1ps
module mmdec_core_model (
  // clock
  input wire logic i_sys_clk,
  // bus toward the decoder
  output logic [15:0] o_addr,
  output logic o_access
);
  // --------------------------------
  // bus driving
  // --------------------------------
  // bus starts idle at time zero
  initial begin
    o_addr = 16'h0000;
    o_access = 1'b0;
  end

  // one access per call on the full 16-bit bus, launched off the falling edge
  // reserved or unimplemented space is only touched when a scenario asks for it
  task automatic access(input logic [15:0] a);
    @(negedge i_sys_clk);
    o_addr <= a;
    o_access <= 1'b1;
  endtask

  // idle: address flips so a stale value never looks like a held request
  task automatic idle();
    @(negedge i_sys_clk);
    o_addr <= ~o_addr;
    o_access <= 1'b0;
  endtask
endmodule

// File: verification/testbench.sv
// self-checking testbench for the memory map address decoder
`timescale 1ns/1ps
module testbench;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_clk_en = 1'b1;
  logic [15:0] bus_addr;
  logic bus_access;
  mmdec_pkg::mmdec_region_t o_region;
  mmdec_pkg::mmdec_sysreg_t o_sysreg;
  logic o_reserved;
  logic o_illegal_rst;
  logic [17:0] got;
  int n_errors = 0;
  int cmp_count = 0;
  localparam logic [15:0] SYS_MAP [11] = '{16'hFE00, 16'hFE01, 16'hFE03, 16'hFE04, 16'hFE05, 16'hFE06,
    16'hFE09, 16'hFE0A, 16'hFE0B, 16'hFE0C, 16'hFFFF};
  localparam logic [15:0] EDGES [17] = '{16'h0000, 16'h003F, 16'h0040, 16'h023F, 16'h0240, 16'hBFFF,
    16'hC000, 16'hFDFF, 16'hFF52, 16'hFF53, 16'hFF7D, 16'hFF7E, 16'hFF7F, 16'hFFDB, 16'hFFDC, 16'hFFFE, 16'hFFFF};

  // 4 ns clock
  always #2 i_sys_clk = ~i_sys_clk;

  mmdec_core_model core (.i_sys_clk(i_sys_clk), .o_addr(bus_addr), .o_access(bus_access));
  mmdec_top dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_clk_en(i_clk_en), .i_addr(bus_addr),
    .i_access(bus_access), .o_region(o_region), .o_sysreg(o_sysreg), .o_reserved(o_reserved),
    .o_illegal_rst(o_illegal_rst));
  assign got = {o_region, o_sysreg, o_reserved, o_illegal_rst};

  // --------------------------------
  // expectation and compare
  // --------------------------------
  // full select word for one access; exactly one hot except the shared top byte
  function automatic logic [17:0] exp_of(input logic [15:0] a);
    logic [4:0] r;
    logic [10:0] s;
    logic rv;
    r = {a <= 16'h003F, a >= 16'h0040 && a <= 16'h023F, a >= 16'hC000 && a <= 16'hFDFF,
      a >= 16'hFE20 && a <= 16'hFF52, a >= 16'hFFDC};
    for (int i = 0; i < 11; i++) begin
      s[10 - i] = (a == SYS_MAP[i]);
    end
    rv = a == 16'hFE02 || a == 16'hFE07 || a == 16'hFE08 || (a >= 16'hFE10 && a <= 16'hFE1F) || a == 16'hFF7E;
    return {r, s, rv, !(|r || |s || rv)};
  endfunction

  task automatic cmp_sel(input logic [17:0] g, input logic [17:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one access, then look at the answer just after the sampling edge
  task automatic check(input logic [15:0] a);
    core.access(a);
    @(posedge i_sys_clk);
    #1;
    cmp_sel(got, exp_of(a));
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic test_reset();
    repeat (10) @(negedge i_sys_clk);
    cmp_sel(got, 18'h0_0000);
    i_nrst <= 1'b1;
    core.idle();
    @(posedge i_sys_clk);
    #1;
    cmp_sel(got, 18'h0_0000);
    $display("test_reset done");
  endtask

  // region boundaries back to back, then every address from $FE00 up to $FE21 across the system registers
  task automatic test_map();
    for (int i = 0; i < 17; i++) check(EDGES[i]);
    for (int a = 16'hFE00; a <= 16'hFE21; a++) check(16'(a));
    $display("test_map done");
  endtask

  // repeated illegal accesses keep the reset request up; an idle cycle clears it
  task automatic test_illegal_run();
    check(16'h1000);
    check(16'h1001);
    core.idle();
    @(posedge i_sys_clk);
    #1;
    cmp_sel(got, 18'h0_0000);
    $display("test_illegal_run done");
  endtask

  // clock enable low freezes the last answer even when the bus moves
  task automatic test_freeze();
    check(16'h0100);
    core.access(16'h1000);
    i_clk_en <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1;
    cmp_sel(got, exp_of(16'h0100));
    @(negedge i_sys_clk);
    i_clk_en <= 1'b1;
    @(posedge i_sys_clk);
    #1;
    cmp_sel(got, exp_of(16'h1000));
    $display("test_freeze done");
  endtask

  // reset in mid-run clears at once, decoding resumes after release
  task automatic test_midreset();
    check(16'hFFFF);
    @(negedge i_sys_clk);
    i_nrst <= 1'b0;
    #1;
    cmp_sel(got, 18'h0_0000);
    core.idle();
    @(negedge i_sys_clk);
    i_nrst <= 1'b1;
    core.idle();
    check(16'hFE0C);
    $display("test_midreset done");
  endtask

  // bounded run: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    n_errors++;
    print_verdict();
  end

  initial begin
    test_reset();
    test_map();
    test_illegal_run();
    test_freeze();
    test_midreset();
    print_verdict();
  end
endmodule
